// >>> logic/slapd_ctrl.sv
/*
  Power-management control: signal-present detector, inactivity timer,
  power state machine and APB register slave with interrupt.
  Assumes asynchronous pin inputs and a free-running 200 MHz pclk.
*/
`timescale 1ns/1ps

// Behaviour
// - Drive signal_present_n low after invalid levels on all receivers exceed 60 us.
// - Return signal_present_n high within 1 us of any valid receiver level.
// - Signal-present detection runs in every power state.
// - signal_present_n never changes the power state by itself.
// - Floating receivers pulled to ground count as invalid.
// - Auto powerdown of pump and transmitters after 30 s without input edges.
// - Leave auto powerdown on any transmitter or receiver input edge.
// - Inactivity powerdown only with force_active low and force_shutdown_n high.
// - force_active disables inactivity powerdown; force_shutdown_n low always powers down.
// - After any powerdown the timer stays expired until force_active rises or an edge.
// - Recovery from automatic powerdown takes about 25 us.
// - With signal_present_n on force_shutdown_n, wake needs valid levels plus an edge.
// - Forced powerdown tristates receivers; any powerdown tristates transmitters.
// - Monitor receiver output stays active in every state.
// - After force_active falls, stay powered for 30 s before inactivity powerdown.
module slapd_ctrl #(
  parameter logic [slapd_pkg::INV_W-1:0]  INVALID_CYC = slapd_pkg::INVALID_CNT,
  parameter logic [slapd_pkg::WAKE_W-1:0] WAKE_CYC    = slapd_pkg::WAKE_CNT,
  parameter logic [slapd_pkg::IDLE_W-1:0] IDLE_CYC    = slapd_pkg::IDLE_CNT
) (
  // Clock, reset, enable
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         pce,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [slapd_pkg::AW-1:0]     paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              irq,
  // Pins and comparators
  input  wire logic [slapd_pkg::NRX-1:0]    rx_valid_lvl,
  input  wire logic [slapd_pkg::NRX-1:0]    rx_in,
  input  wire logic [slapd_pkg::NTX-1:0]    tx_in,
  input  wire logic                         monitor_rx_in,
  input  wire logic                         force_active,
  input  wire logic                         force_shutdown_n,
  // Outputs to the line side
  output logic                              signal_present_n,
  output logic                              pump_en,
  output logic      [slapd_pkg::NTX-1:0]    tx_out,
  output logic                              tx_oe_n,
  output logic      [slapd_pkg::NRX-1:0]    rx_out,
  output logic                              rx_oe_n,
  output logic                              monitor_rx_out
);

  slapd_pkg::slapd_state_t st_r;
  slapd_pkg::slapd_state_t st_nxt;

  logic [slapd_pkg::NIN-1:0] pins;
  logic [slapd_pkg::NIN-1:0] flt_nxt;
  logic                      act_edge;
  logic                      any_valid;
  logic                      fa_f;
  logic                      fsn_f;

  // Address decode: {hit, index}
  function automatic logic [2:0] slapd_dec(input logic [slapd_pkg::AW-1:0] a);
    logic [2:0] r;
    r = 3'h0;
    case (a)
      slapd_pkg::A_CTRL:     r = 3'h4;
      slapd_pkg::A_STATUS:   r = 3'h5;
      slapd_pkg::A_IRQ_STAT: r = 3'h6;
      slapd_pkg::A_IRQ_MASK: r = 3'h7;
      default:               r = 3'h0;
    endcase
    return r;
  endfunction : slapd_dec

  assign pins = {force_shutdown_n, force_active, monitor_rx_in, tx_in, rx_in, rx_valid_lvl};

  // Value accepted once stages two and three agree
  assign flt_nxt   = (st_r.flt & (st_r.s2 ^ st_r.s3)) | (st_r.s3 & ~(st_r.s2 ^ st_r.s3));
  assign act_edge  = |((flt_nxt ^ st_r.flt) & slapd_pkg::ACT_MASK);
  assign any_valid = |st_r.flt[slapd_pkg::B_RXV +: slapd_pkg::NRX];
  assign fa_f      = st_r.flt[slapd_pkg::B_FA];
  assign fsn_f     = st_r.flt[slapd_pkg::B_FSN];

  always_comb begin
    logic [2:0]             dec;
    logic                   wr;
    logic [slapd_pkg::IRQ_W-1:0] ev;
    logic [slapd_pkg::IRQ_W-1:0] w1c;
    logic                   was_off;
    dec     = slapd_dec(paddr);
    wr      = 1'b0;
    ev      = '0;
    w1c     = '0;
    was_off = 1'b0;
    st_nxt  = st_r;
    if (pce) begin
      // Synchroniser chain
      st_nxt.s1  = pins;
      st_nxt.s2  = st_r.s1;
      st_nxt.s3  = st_r.s2;
      st_nxt.flt = flt_nxt;

      // Signal-present detector, independent of power state
      if (any_valid) begin
        st_nxt.inv_cnt = '0;
        st_nxt.sp_n    = 1'b1;
      end else if (st_r.inv_cnt == INVALID_CYC) begin
        st_nxt.sp_n = 1'b0;
      end else begin
        st_nxt.inv_cnt = st_r.inv_cnt + 1'b1;
      end

      // Inactivity timer
      if (fa_f || !st_r.auto_en) begin
        st_nxt.idle_cnt = '0;
        st_nxt.expired  = 1'b0;
      end else if (!fsn_f) begin
        st_nxt.idle_cnt = '0;
        st_nxt.expired  = 1'b1;
      end else if (act_edge) begin
        st_nxt.idle_cnt = '0;
        st_nxt.expired  = 1'b0;
      end else if (st_r.pwr == slapd_pkg::PWR_AUTO_OFF) begin
        st_nxt.expired = 1'b1;
      end else if (!st_r.expired) begin
        if (st_r.idle_cnt == IDLE_CYC - 1'b1) begin
          st_nxt.expired = 1'b1;
        end else begin
          st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
        end
      end

      // Power state; the detector output is not an input here
      was_off = (st_r.pwr == slapd_pkg::PWR_AUTO_OFF) ||
                (st_r.pwr == slapd_pkg::PWR_FORCED_OFF);
      case (st_r.pwr)
        slapd_pkg::PWR_ON: begin
          if (!fsn_f) begin
            st_nxt.pwr = slapd_pkg::PWR_FORCED_OFF;
          end else if (!fa_f && st_r.auto_en && st_r.expired) begin
            st_nxt.pwr = slapd_pkg::PWR_AUTO_OFF;
          end
        end
        slapd_pkg::PWR_AUTO_OFF: begin
          if (!fsn_f) begin
            st_nxt.pwr = slapd_pkg::PWR_FORCED_OFF;
          end else if (!st_nxt.expired) begin
            st_nxt.pwr      = slapd_pkg::PWR_WAKING;
            st_nxt.wake_cnt = '0;
          end
        end
        slapd_pkg::PWR_FORCED_OFF: begin
          if (fsn_f && !st_nxt.expired) begin
            st_nxt.pwr      = slapd_pkg::PWR_WAKING;
            st_nxt.wake_cnt = '0;
          end
        end
        slapd_pkg::PWR_WAKING: begin
          if (!fsn_f) begin
            st_nxt.pwr = slapd_pkg::PWR_FORCED_OFF;
          end else if (st_r.wake_cnt == WAKE_CYC - 1'b1) begin
            st_nxt.pwr = slapd_pkg::PWR_ON;
          end else begin
            st_nxt.wake_cnt = st_r.wake_cnt + 1'b1;
          end
        end
        default: st_nxt.pwr = slapd_pkg::PWR_FORCED_OFF;
      endcase

      // Events
      ev[slapd_pkg::EV_SP_FELL]  = st_r.sp_n && !st_nxt.sp_n;
      ev[slapd_pkg::EV_SP_ROSE]  = !st_r.sp_n && st_nxt.sp_n;
      ev[slapd_pkg::EV_PWR_DOWN] = !was_off &&
                                   ((st_nxt.pwr == slapd_pkg::PWR_AUTO_OFF) ||
                                    (st_nxt.pwr == slapd_pkg::PWR_FORCED_OFF));
      ev[slapd_pkg::EV_PWR_UP]   = (st_r.pwr != slapd_pkg::PWR_ON) &&
                                   (st_nxt.pwr == slapd_pkg::PWR_ON);

      // APB: read data captured in setup, writes in access
      if (psel && !penable) begin
        st_nxt.pslverr = !dec[2];
        case (dec)
          3'h4:    st_nxt.prdata = 32'(st_r.auto_en) << slapd_pkg::CTRL_AUTO;
          3'h5:    st_nxt.prdata = (32'(st_r.sp_n) << slapd_pkg::ST_SP_N) |
                     (32'(st_r.pwr != slapd_pkg::PWR_AUTO_OFF &&
                          st_r.pwr != slapd_pkg::PWR_FORCED_OFF) << slapd_pkg::ST_PUMP) |
                     (32'(st_r.pwr == slapd_pkg::PWR_FORCED_OFF) << slapd_pkg::ST_FORCED) |
                     (32'(st_r.pwr == slapd_pkg::PWR_AUTO_OFF) << slapd_pkg::ST_AUTO) |
                     (32'(st_r.expired) << slapd_pkg::ST_EXPIRED);
          3'h6:    st_nxt.prdata = 32'(st_r.irq_stat);
          3'h7:    st_nxt.prdata = 32'(st_r.irq_mask);
          default: st_nxt.prdata = 32'h0000_0000;
        endcase
      end
      wr = psel && penable && pwrite && dec[2];
      if (wr && dec[1:0] == 2'h0) begin
        st_nxt.auto_en = pwdata[slapd_pkg::CTRL_AUTO];
      end
      if (wr && dec[1:0] == 2'h3) begin
        st_nxt.irq_mask = pwdata[slapd_pkg::IRQ_W-1:0];
      end
      if (wr && dec[1:0] == 2'h2) begin
        w1c = pwdata[slapd_pkg::IRQ_W-1:0];
      end
      // Set wins over clear
      st_nxt.irq_stat = (st_r.irq_stat & ~w1c) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= slapd_pkg::STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata           = st_r.prdata;
  assign pslverr          = st_r.pslverr;
  assign pready           = pce;
  assign irq              = |(st_r.irq_stat & st_r.irq_mask);
  assign signal_present_n = st_r.sp_n;
  assign pump_en          = (st_r.pwr == slapd_pkg::PWR_ON) ||
                            (st_r.pwr == slapd_pkg::PWR_WAKING);
  assign tx_out           = st_r.flt[slapd_pkg::B_TX +: slapd_pkg::NTX];
  assign tx_oe_n          = (st_r.pwr != slapd_pkg::PWR_ON);
  assign rx_out           = ~st_r.flt[slapd_pkg::B_RX +: slapd_pkg::NRX];
  assign rx_oe_n          = (st_r.pwr == slapd_pkg::PWR_FORCED_OFF);
  assign monitor_rx_out   = st_r.flt[slapd_pkg::B_MON];

  // Checks
  a_sp_fall_time: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(signal_present_n) |-> $past(st_r.inv_cnt) == INVALID_CYC)
    else $error("signal present fell at wrong count");

  a_sp_rise_fast: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && any_valid) |=> signal_present_n && st_r.inv_cnt == '0)
    else $error("signal present slow to rise");

  a_sp_forced_off: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && st_r.pwr == slapd_pkg::PWR_FORCED_OFF && !any_valid &&
     st_r.inv_cnt == INVALID_CYC) |=> !signal_present_n)
    else $error("detector stopped in forced powerdown");

  a_idle_off: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && st_r.pwr == slapd_pkg::PWR_ON && fsn_f && !fa_f && st_r.auto_en &&
     st_r.expired) |=> st_r.pwr == slapd_pkg::PWR_AUTO_OFF)
    else $error("no inactivity powerdown");

  a_wake_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && st_r.pwr == slapd_pkg::PWR_AUTO_OFF && fsn_f && act_edge)
    |=> st_r.pwr == slapd_pkg::PWR_WAKING)
    else $error("edge did not wake");

  a_forced_off: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && !fsn_f) |=> st_r.pwr == slapd_pkg::PWR_FORCED_OFF)
    else $error("force shutdown ignored");

  a_force_active: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && fa_f) |=> !st_r.expired && st_r.idle_cnt == '0)
    else $error("timer not held by force active");

  a_stay_expired: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && st_r.expired && !fa_f && st_r.auto_en && !act_edge) |=> st_r.expired)
    else $error("timer left expired state");

  a_wake_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r.pwr == slapd_pkg::PWR_ON) |-> $past(st_r.wake_cnt) == WAKE_CYC - 1'b1)
    else $error("wake time wrong");

  a_oe_forced: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && !fsn_f) |=> rx_oe_n && tx_oe_n && !pump_en)
    else $error("outputs driven in forced powerdown");

  a_monitor_live: assert property (@(posedge pclk) disable iff (!presetn)
    (pce && st_r.s2[slapd_pkg::B_MON] == st_r.s3[slapd_pkg::B_MON])
    |=> monitor_rx_out == $past(st_r.s3[slapd_pkg::B_MON]))
    else $error("monitor output not following input");

endmodule : slapd_ctrl

// >>> logic/slapd_pkg.sv
/*
  Constants, types and register map of the serial line autopowerdown control.
  Assumes a 200 MHz pclk and comparator valid-level flags per receiver.
*/
package slapd_pkg;

  // Channel counts
  localparam int unsigned NRX = 3;
  localparam int unsigned NTX = 5;

  // Positions in the synchronised input vector
  localparam int unsigned B_RXV = 0;
  localparam int unsigned B_RX  = B_RXV + NRX;
  localparam int unsigned B_TX  = B_RX + NRX;
  localparam int unsigned B_MON = B_TX + NTX;
  localparam int unsigned B_FA  = B_MON + 1;
  localparam int unsigned B_FSN = B_FA + 1;
  localparam int unsigned NIN   = B_FSN + 1;

  localparam logic [NIN-1:0] IN_RST   = NIN'(1) << B_FSN;
  localparam logic [NIN-1:0] ACT_MASK = ((NIN'(1) << (NRX + NTX)) - NIN'(1)) << B_RX;

  // Timing
  localparam int unsigned  CLK_MHZ     = 200;
  localparam longint unsigned US_PER_S = 1_000_000;
  localparam int unsigned  INVALID_US  = 60;
  localparam int unsigned  VALID_US    = 1;
  localparam int unsigned  WAKE_US     = 25;
  localparam int unsigned  IDLE_S      = 30;
  localparam int unsigned  INVALID_CYC = INVALID_US * CLK_MHZ;
  localparam int unsigned  VALID_CYC   = VALID_US * CLK_MHZ;
  localparam int unsigned  WAKE_CYC    = WAKE_US * CLK_MHZ;
  localparam longint unsigned IDLE_CYC = longint'(IDLE_S) * longint'(CLK_MHZ) * US_PER_S;

  localparam int unsigned INV_W  = $clog2(INVALID_CYC + 1);
  localparam int unsigned WAKE_W = $clog2(WAKE_CYC + 1);
  localparam int unsigned IDLE_W = $clog2(IDLE_CYC + 1);

  localparam logic [INV_W-1:0]  INVALID_CNT = INV_W'(INVALID_CYC);
  localparam logic [WAKE_W-1:0] WAKE_CNT    = WAKE_W'(WAKE_CYC);
  localparam logic [IDLE_W-1:0] IDLE_CNT    = IDLE_W'(IDLE_CYC);

  // Register map
  localparam int unsigned     AW           = 8;
  localparam logic [AW-1:0]   A_CTRL       = 8'h00;
  localparam logic [AW-1:0]   A_STATUS     = 8'h04;
  localparam logic [AW-1:0]   A_IRQ_STAT   = 8'h08;
  localparam logic [AW-1:0]   A_IRQ_MASK   = 8'h0C;
  localparam int unsigned     CTRL_AUTO    = 0;
  localparam int unsigned     ST_SP_N      = 0;
  localparam int unsigned     ST_PUMP      = 1;
  localparam int unsigned     ST_FORCED    = 2;
  localparam int unsigned     ST_AUTO      = 3;
  localparam int unsigned     ST_EXPIRED   = 4;
  localparam int unsigned     IRQ_W        = 4;
  localparam int unsigned     EV_SP_FELL   = 0;
  localparam int unsigned     EV_SP_ROSE   = 1;
  localparam int unsigned     EV_PWR_DOWN  = 2;
  localparam int unsigned     EV_PWR_UP    = 3;

  typedef enum logic [1:0] {PWR_ON, PWR_AUTO_OFF, PWR_FORCED_OFF, PWR_WAKING} slapd_pwr_t;

  typedef struct packed {
    logic [NIN-1:0]    s1;
    logic [NIN-1:0]    s2;
    logic [NIN-1:0]    s3;
    logic [NIN-1:0]    flt;
    logic              sp_n;
    logic [INV_W-1:0]  inv_cnt;
    logic [IDLE_W-1:0] idle_cnt;
    logic              expired;
    slapd_pwr_t        pwr;
    logic [WAKE_W-1:0] wake_cnt;
    logic              auto_en;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [31:0]       prdata;
    logic              pslverr;
  } slapd_state_t;

  localparam slapd_state_t STATE_RST = '{
    s1: IN_RST, s2: IN_RST, s3: IN_RST, flt: IN_RST, sp_n: 1'b1,
    inv_cnt: '0, idle_cnt: '0, expired: 1'b0, pwr: PWR_WAKING, wake_cnt: '0,
    auto_en: 1'b1, irq_stat: '0, irq_mask: '0, prdata: '0, pslverr: 1'b0};

endpackage : slapd_pkg

// >>> bench/slapd_host_model.sv
/*
  Host power-management model that drives the two force pins.
  Assumes the bench picks the wiring mode and the manual pin levels.
*/
`timescale 1ns/1ps
module slapd_host_model (
  // Mode: 0 manual, 1 both tied, 2 shutdown tied
  input  wire logic [1:0] mode,
  input  wire logic       man_active,
  input  wire logic       man_shutdown_n,
  // Device side
  input  wire logic       signal_present_n,
  output logic            force_active,
  output logic            force_shutdown_n
);
  always_comb begin
    force_active     = man_active;
    force_shutdown_n = man_shutdown_n;
    if (mode == 2'h1) begin
      force_active     = signal_present_n;
      force_shutdown_n = signal_present_n;
    end else if (mode == 2'h2) begin
      force_active     = 1'b0;
      force_shutdown_n = signal_present_n;
    end
  end
endmodule : slapd_host_model

// >>> bench/testbench.sv
/*
  Self-checking bench for the autopowerdown control, scenario per task.
  Assumes shortened counts and a host model on the force pins.
*/
`timescale 1ns/1ps
module testbench;
  localparam int P_INV  = 20;
  localparam int P_WAKE = 10;
  localparam int P_IDLE = 50;
  logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [slapd_pkg::AW-1:0]   paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic [slapd_pkg::NRX-1:0]  rx_valid_lvl, rx_in, rx_out;
  logic [slapd_pkg::NTX-1:0]  tx_in, tx_out;
  logic                       monitor_rx_in, monitor_rx_out, fa, fsn, sp_n, pump_en;
  logic                       tx_oe_n, rx_oe_n, man_a, man_sn, err, pce;
  logic [1:0]                 mode;
  int                         error_cnt, n_checks;

  slapd_host_model host (.mode(mode), .man_active(man_a), .man_shutdown_n(man_sn),
    .signal_present_n(sp_n), .force_active(fa), .force_shutdown_n(fsn));
  slapd_ctrl #(.INVALID_CYC(slapd_pkg::INV_W'(P_INV)), .WAKE_CYC(slapd_pkg::WAKE_W'(P_WAKE)),
    .IDLE_CYC(slapd_pkg::IDLE_W'(P_IDLE))) dut (.pclk(pclk), .presetn(presetn), .pce(pce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .rx_valid_lvl(rx_valid_lvl), .rx_in(rx_in), .tx_in(tx_in), .monitor_rx_in(monitor_rx_in),
    .force_active(fa), .force_shutdown_n(fsn), .signal_present_n(sp_n), .pump_en(pump_en),
    .tx_out(tx_out), .tx_oe_n(tx_oe_n), .rx_out(rx_out), .rx_oe_n(rx_oe_n),
    .monitor_rx_out(monitor_rx_out));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic results();
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask : chk

  // Pin selector: sp_n, pump, tx_oe_n, rx_oe_n
  function automatic logic pin(input int k);
    case (k)
      0: pin = sp_n;
      1: pin = pump_en;
      2: pin = tx_oe_n;
      default: pin = rx_oe_n;
    endcase
  endfunction : pin

  task automatic wait_pin(input int k, input logic v, input int lim);
    for (int i = 0; i < lim && pin(k) !== v; i++) @(posedge pclk);
    if (pin(k) !== v) begin
      chk(1'b0, "pin wait ran out");
      results();
    end
  endtask : wait_pin

  task automatic hold_pin(input int k, input logic v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge pclk);
      if (pin(k) !== v) ok = 1'b0;
    end
    chk(ok, "pin changed too early");
  endtask : hold_pin

  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(1'b0, "no pready");
      results();
    end
    // Let register updates of the access edge settle before callers look
    @(negedge pclk);
  endtask : apb

  task automatic t_regs();
    wait_pin(2, 1'b0, P_WAKE + 20);
    pce <= 1'b0;
    @(negedge pclk);
    chk(pready === 1'b0, "pready with enable low");
    @(posedge pclk);
    pce <= 1'b1;
    apb(slapd_pkg::A_CTRL, 1'b0, 32'h0);
    chk(rd === 32'h1 && err === 1'b0, "CTRL reset value");
    apb(slapd_pkg::A_IRQ_MASK, 1'b0, 32'h0);
    chk(rd === 32'h0, "mask reset value");
    apb(8'h10, 1'b0, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    apb(slapd_pkg::A_IRQ_MASK, 1'b1, 32'hF);
    apb(slapd_pkg::A_CTRL, 1'b1, 32'h0);
  endtask : t_regs

  task automatic t_sigdet();
    rx_valid_lvl <= 3'h0;
    hold_pin(0, 1'b1, P_INV);
    wait_pin(0, 1'b0, 12);
    chk(pump_en === 1'b1 && tx_oe_n === 1'b0, "power moved with sp_n");
    rx_valid_lvl <= 3'h4;
    wait_pin(0, 1'b1, 200);
    apb(slapd_pkg::A_IRQ_STAT, 1'b0, 32'h0);
    chk(rd[1:0] === 2'h3 && irq === 1'b1, "sp events not flagged");
    apb(slapd_pkg::A_IRQ_STAT, 1'b1, 32'hF);
    chk(irq === 1'b0, "irq not cleared");
    rx_valid_lvl <= 3'h7;
    apb(slapd_pkg::A_CTRL, 1'b1, 32'h1);
  endtask : t_sigdet

  task automatic t_auto();
    hold_pin(1, 1'b1, P_IDLE - 5);
    wait_pin(1, 1'b0, 20);
    chk(tx_oe_n === 1'b1 && rx_oe_n === 1'b0, "auto off outputs");
    chk(irq === 1'b1, "powerdown irq");
    monitor_rx_in <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(monitor_rx_out === 1'b1, "monitor output");
    rx_valid_lvl <= 3'h0;
    wait_pin(0, 1'b0, P_INV + 12);
    rx_valid_lvl <= 3'h7;
    wait_pin(0, 1'b1, 12);
    chk(pump_en === 1'b0, "woke on level");
    tx_in <= 5'h10;
    wait_pin(1, 1'b1, 8);
    hold_pin(2, 1'b1, P_WAKE - 2);
    wait_pin(2, 1'b0, 8);
    chk(tx_out === 5'h10 && rx_out === 3'h7, "line data outputs");
  endtask : t_auto

  task automatic t_force();
    man_a <= 1'b1;
    hold_pin(1, 1'b1, 2 * P_IDLE);
    man_sn <= 1'b0;
    wait_pin(3, 1'b1, 8);
    chk(pump_en === 1'b0 && tx_oe_n === 1'b1, "forced off outputs");
    rx_in <= 3'h1;
    man_a <= 1'b0;
    hold_pin(1, 1'b0, 10);
    man_sn <= 1'b1;
    hold_pin(1, 1'b0, 30);
    rx_in <= 3'h0;
    wait_pin(1, 1'b1, 8);
    wait_pin(2, 1'b0, P_WAKE + 8);
  endtask : t_force

  task automatic t_release();
    man_a <= 1'b1;
    repeat (20) @(posedge pclk);
    man_a <= 1'b0;
    hold_pin(1, 1'b1, P_IDLE - 5);
    wait_pin(1, 1'b0, 20);
  endtask : t_release

  task automatic t_tie();
    mode <= 2'h1;
    rx_valid_lvl <= 3'h0;
    wait_pin(3, 1'b1, P_INV + 15);
    rx_valid_lvl <= 3'h2;
    wait_pin(2, 1'b0, P_WAKE + 20);
    mode <= 2'h2;
    rx_valid_lvl <= 3'h0;
    wait_pin(3, 1'b1, P_INV + 15);
    rx_valid_lvl <= 3'h7;
    hold_pin(1, 1'b0, 30);
    tx_in <= 5'h11;
    wait_pin(1, 1'b1, 8);
  endtask : t_tie

  initial begin
    presetn       <= 1'b0;
    pce           <= 1'b1;
    {psel, penable, pwrite, monitor_rx_in, man_a} <= 5'h0;
    paddr         <= 8'h00;
    pwdata        <= 32'h0;
    rx_valid_lvl  <= 3'h7;
    rx_in         <= 3'h0;
    tx_in         <= 5'h00;
    man_sn        <= 1'b1;
    mode          <= 2'h0;
    error_cnt     = 0;
    n_checks      = 0;
    repeat (10) @(posedge pclk);
    chk(pump_en === 1'b1 && tx_oe_n === 1'b1 && rx_oe_n === 1'b0, "reset outputs");
    presetn <= 1'b1;
    t_regs();
    t_sigdet();
    t_auto();
    t_force();
    t_release();
    t_tie();
    results();
  end
endmodule : testbench
